// ---- bench/osc_properties.sv ----
// assertions on the sensor configuration ports
`timescale 1ns/100ps
module osc_properties(input wire logic pclk,presetn,psel,penable,pwrite,pready,pslverr,
input wire logic [11:0] paddr,input wire logic [31:0] pwdata,prdata,input wire logic [3:0] pstrb,
input wire logic [2:0] adc_reference_select,
input osc_pkg::osc_sensor_t digital_regulator_sensor,analog_regulator_sensor,bottom_centre_sensor);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [5:0] d=digital_regulator_sensor,a=analog_regulator_sensor,b=bottom_centre_sensor;
    wire w=psel&&penable&&pwrite&&pstrb==4'hf,r=psel&&penable&&!pwrite;
    property p_d; w&&paddr==12'h0 |=> d==$past(pwdata[11:6]); endproperty
    a_d: assert property(p_d) else $error("bad field");
    property p_a; w&&paddr==12'h0 |=> a==$past(pwdata[5:0]); endproperty
    a_a: assert property(p_a) else $error("bad field");
    property p_b; w&&paddr==12'h4 |=> b==$past(pwdata[5:0]); endproperty
    a_b: assert property(p_b) else $error("bad field");
    property p_r; w&&paddr==12'h8 |=> adc_reference_select==$past(pwdata[2:0]); endproperty
    a_r: assert property(p_r) else $error("bad field");
    property p_s; !(psel&&penable&&pwrite) |=> $stable({d,a,b,adc_reference_select}); endproperty
    a_s: assert property(p_s) else $error("moved");
    property p_e; psel&&penable |-> pready&&pslverr==(paddr>12'h8||paddr[1:0]!=2'h0); endproperty
    a_e: assert property(p_e) else $error("bad answer");
    property p_q; r&&paddr==12'h0 |-> prdata=={20'h0,d,a}; endproperty
    a_q: assert property(p_q) else $error("bad read");
    property p_z; r&&paddr==12'h4 |-> prdata=={26'h0,b}; endproperty
    a_z: assert property(p_z) else $error("bad read");
endmodule // osc_properties
bind osc_sensor_config osc_properties u_props(.*);

// ---- bench/osc_sensor_model.sv ----
// bias switch model: current multiple seen by one sensor
`timescale 1ns/100ps
module osc_sensor_model(input osc_pkg::osc_sensor_t s,output logic [3:0] m);
    assign m=!s.enable?4'h0:s.bias_select?4'hf:4'h1;
endmodule // osc_sensor_model

// ---- bench/testbench.sv ----
// self-checking bench of the sensor configuration block
`timescale 1ns/100ps
module testbench;
    logic pclk=0,presetn=0,psel=0,penable=0,pwrite=0,pready,pslverr;
    logic [11:0] paddr=12'h0;
    logic [31:0] pwdata=32'h0,prdata,rd;
    logic er;
    logic [3:0] pstrb=4'hf,m;
    logic [2:0] adc;
    osc_pkg::osc_sensor_t dg,an,bt;
    int n_mismatch=0,checks_done=0,cyc=0;
    logic [43:0] row[4]='{{12'h0,32'habc},{12'h4,32'h3c},{12'h8,32'h4},{12'hc,32'h0}};
    osc_sensor_config DUT(.*,.digital_regulator_sensor(dg),.analog_regulator_sensor(an),
        .bottom_centre_sensor(bt),.adc_reference_select(adc));
    osc_sensor_model u_model(.s(an),.m(m));
    always #5 pclk=~pclk;
    always @(posedge pclk) if (++cyc>2000) begin
        n_mismatch++;
        report_and_stop;
    end
    task ck(input logic [43:0] s,e);
        checks_done++;
        if (s!==e) begin
            n_mismatch++;
            $display("Error %0t got %h want %h",$time,s,e);
        end
    endtask
    task apb(input logic w,input logic [11:0] a,input logic [31:0] dt);
        psel<=1; pwrite<=w; paddr<=a; pwdata<=dt;
        @(posedge pclk) penable<=1;
        do @(posedge pclk); while (pready!==1'b1);
        rd=prdata;
        er=pslverr;
        psel<=0; penable<=0;
        @(posedge pclk);
    endtask
    task report_and_stop;
        $display("mismatches %0d checks %0d",n_mismatch,checks_done);
        if (n_mismatch==0&&checks_done>0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        ck({dg,an,bt,adc},44'h0);
        presetn<=1;
        foreach (row[i]) begin
            apb(1,row[i][43:32],32'hffff_fabc);
            apb(0,row[i][43:32],32'h0);
            ck(rd,row[i][31:0]);
            ck(er,row[i][43:32]==12'hc);
        end
        // monitor enable and channel pick stay outside this block
        ck(adc,3'h4);
        // sweep every code at unit bias, then at fifteen times
        for (int i=0; i<32; i++) begin
            apb(1,12'h0,{26'h0,1'b1,i[3:0],i[4]});
            ck({bt,dg,an,m},{6'h3c,6'h0,1'b1,i[3:0],i[4],i[4]?4'hf:4'h1});
        end
        // only the upper lane lands; the lower lane is refused
        pstrb<=4'h2;
        apb(1,12'h0,32'h0000_0fc0);
        pstrb<=4'hf;
        apb(0,12'h0,32'h0);
        ck(rd,32'h0000_0f3f);
        ck(dg,6'h3c);
        presetn<=0;
        @(posedge pclk);
        ck({dg,an,bt,adc},44'h0);
        report_and_stop;
    end
endmodule // testbench

// ---- design/osc_field_decode.sv ----
// decode of one six-bit sensor field into its control outputs
`timescale 1ns/100ps
module osc_field_decode (
    input wire logic [5:0] field,
    output osc_pkg::osc_sensor_t sensor
);
    assign sensor.enable = field[5];
    assign sensor.rotation_code = field[4:1];
    assign sensor.bias_select = osc_pkg::osc_bias_t'(field[0]);
endmodule // osc_field_decode

// ---- design/osc_sensor_config.sv ----
// apb register file driving the transistor sensor enables, codes and bias selects
`timescale 1ns/100ps
`include "osc_cfg.svh"

// What this block does
// - two 12-bit registers, regulator sensors and bottom-centre sensor.
// - regulator register bits 11, 10-7, 6 drive digital-regulator sensor.
// - regulator register bits 5, 4-1, 0 drive analog-regulator sensor.
// - bottom register uses bits 5, 4-1, 0 for its sensor.
// - bias select zero gives unit current, one fifteen times.
// - resistor sensors have no bits; only converter reference setting matters.
// - three transistor sensor locations, each enabled on its own.
// - three-bit converter reference select; non-default options serve resistor sensors.
module osc_sensor_config (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output osc_pkg::osc_sensor_t digital_regulator_sensor,
    output osc_pkg::osc_sensor_t analog_regulator_sensor,
    output osc_pkg::osc_sensor_t bottom_centre_sensor,
    output logic [2:0] adc_reference_select
);
    osc_pkg::osc_state_t st_r;
    osc_pkg::osc_state_t st_nxt;
    logic access;
    logic hit_reg;
    logic hit_bot;
    logic hit_ref;
    logic mapped;

    assign access = psel & penable;
    assign hit_reg = (paddr == `OSC_OFS_REGULATOR);
    assign hit_bot = (paddr == `OSC_OFS_BOTTOM);
    assign hit_ref = (paddr == `OSC_OFS_ADC_REF);
    assign mapped = hit_reg | hit_bot | hit_ref;

    always_comb begin
        st_nxt = st_r;
        if (psel & ~penable) begin
            st_nxt.prdata_r = 32'h0000_0000;
            if (hit_reg) begin
                st_nxt.prdata_r = {20'h00000, st_r.regulator_r};
            end else if (hit_bot) begin
                st_nxt.prdata_r = {20'h00000, st_r.bottom_r & `OSC_BOTTOM_MASK};
            end else if (hit_ref) begin
                st_nxt.prdata_r = {29'h0000000, st_r.adc_ref_r};
            end
        end
        if (access & pwrite) begin
            if (hit_reg) begin
                if (pstrb[0]) begin
                    st_nxt.regulator_r[7:0] = pwdata[7:0];
                end
                if (pstrb[1]) begin
                    st_nxt.regulator_r[11:8] = pwdata[11:8];
                end
            end
            if (hit_bot && pstrb[0]) begin
                st_nxt.bottom_r = {6'h00, pwdata[5:0]};
            end
            if (hit_ref && pstrb[0]) begin
                st_nxt.adc_ref_r = pwdata[2:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.regulator_r <= `OSC_RST_REGULATOR;
            st_r.bottom_r <= `OSC_RST_BOTTOM;
            st_r.adc_ref_r <= `OSC_RST_ADC_REF;
            st_r.prdata_r <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = st_r.prdata_r;
    assign adc_reference_select = st_r.adc_ref_r;

    osc_field_decode u_dig (
        .field(st_r.regulator_r[`OSC_HI_EN:`OSC_HI_BIAS]),
        .sensor(digital_regulator_sensor)
    );
    osc_field_decode u_ana (
        .field(st_r.regulator_r[`OSC_LO_EN:`OSC_LO_BIAS]),
        .sensor(analog_regulator_sensor)
    );
    osc_field_decode u_bot (
        .field(st_r.bottom_r[`OSC_LO_EN:`OSC_LO_BIAS]),
        .sensor(bottom_centre_sensor)
    );
endmodule // osc_sensor_config

// ---- include/osc_cfg.svh ----
// register offsets, field positions and reset values of the sensor configuration block
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH
`define OSC_REG_W 12
`define OSC_OFS_REGULATOR 12'h000
`define OSC_OFS_BOTTOM 12'h004
`define OSC_OFS_ADC_REF 12'h008
`define OSC_HI_EN 11
`define OSC_HI_CODE_MSB 10
`define OSC_HI_CODE_LSB 7
`define OSC_HI_BIAS 6
`define OSC_LO_EN 5
`define OSC_LO_CODE_MSB 4
`define OSC_LO_CODE_LSB 1
`define OSC_LO_BIAS 0
`define OSC_BOTTOM_MASK 12'h03f
`define OSC_RST_REGULATOR 12'h000
`define OSC_RST_BOTTOM 12'h000
`define OSC_RST_ADC_REF 3'h0
`define OSC_REF_W 3
`endif

// ---- include/osc_pkg.sv ----
// types of the on-die sensor configuration block
package osc_pkg;
    // bias select: zero gives unit current, one gives fifteen times unit
    typedef enum logic {
        OSC_BIAS_UNIT = 1'b0,
        OSC_BIAS_X15 = 1'b1
    } osc_bias_t;

    typedef struct packed {
        logic enable;
        logic [3:0] rotation_code;
        osc_bias_t bias_select;
    } osc_sensor_t;

    typedef struct packed {
        logic [11:0] regulator_r;
        logic [11:0] bottom_r;
        logic [2:0] adc_ref_r;
        logic [31:0] prdata_r;
    } osc_state_t;
endpackage
